// [core/bhs_pkg.sv]
/*
 * constants shared by the buck fault and hiccup sequencer:
 * register map, field positions, reset values, timing counts, states.
 * assumes a 125 MHz system clock and a 32-bit ahb-lite register bus.
 */
package bhs_pkg;

	////////////////////////////////////////////////////////////////
	// clock and timing
	localparam int MCLK_KHZ       = 125000;
	localparam int EXT_LOSS_NS    = 10000;    // no falling edge this long: clock gone
	localparam int EXT_LOSS_CYC   = (EXT_LOSS_NS * (MCLK_KHZ / 1000)) / 1000;
	localparam int OC_PERSIST     = 512;      // switching cycles of overload allowed
	localparam int OC_HICCUP      = 16384;    // switching cycles off after overload
	localparam int OT_HICCUP      = 32768;    // switching cycles off after overheat
	localparam int TMR_W          = 16;
	localparam int OCC_W          = 10;
	localparam int LOSS_W         = 12;
	localparam int STRAP_SETTLE   = 2;        // cycles after reset before straps read

	////////////////////////////////////////////////////////////////
	// register map, byte addresses
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_OSC_DIV = 8'h04;
	localparam logic [7:0] ADDR_STATUS  = 8'h08;

	// control fields
	localparam int CTRL_SW_OFF_BIT  = 0;
	localparam int CTRL_FORCE_INT   = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;

	// oscillator divider, mclk cycles per switching cycle (500 kHz)
	localparam logic [15:0] OSC_DIV_RST = 16'h00fa;

	// status fields
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_EXT_BIT   = 3;
	localparam int STAT_PG_BIT    = 4;
	localparam int STAT_OVP_BIT   = 5;
	localparam int STAT_OT_BIT    = 6;
	localparam int STAT_ADDR_LSB  = 7;

	////////////////////////////////////////////////////////////////
	// sequencer states, gray along off, soft start, run
	typedef enum logic [2:0] {
		ST_OFF     = 3'b000,
		ST_SOFT    = 3'b001,
		ST_RUN     = 3'b011,
		ST_OC_HIC  = 3'b010,
		ST_OT_WAIT = 3'b110,
		ST_OT_HIC  = 3'b111
	} bhs_state_type;

endpackage : bhs_pkg

// [core/bhs_sync2.sv]
/*
 * two flip-flop synchroniser for a bundle of asynchronous levels.
 * assumes each bit is a slow level; no multi-bit coherence is implied.
 */
`timescale 1ns/1ps

module bhs_sync2 #(
	parameter int W = 1
) (
	input  wire logic         i_mclk,
	input  wire logic         i_rstn,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] sync_reg;
	logic [W-1:0] sync_next;

	// first stage feeds only the second stage
	always_comb
	begin
		meta_next = i_async;
		sync_next = meta_reg;
		if (!i_rstn)
		begin
			meta_next = '0;
			sync_next = '0;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		meta_reg <= meta_next;
		sync_reg <= sync_next;
	end

	assign o_sync = sync_reg;

endmodule : bhs_sync2

// [core/bhs_sequencer.sv]
/*
 * digital protection and sequencing for a synchronous step-down converter:
 * switching-cycle tick, overcurrent and thermal hiccup, overvoltage block,
 * power-good flag, bootstrap refresh, address straps, ahb-lite registers.
 * assumes analog comparators and pins arrive asynchronously, and that the
 * power stage honours the allow outputs on its own switching edges.
 */
`timescale 1ns/1ps

module bhs_sequencer #(
	parameter int OC_PERSIST_CYC = bhs_pkg::OC_PERSIST,
	parameter int OC_HICCUP_CYC  = bhs_pkg::OC_HICCUP,
	parameter int OT_HICCUP_CYC  = bhs_pkg::OT_HICCUP
) (
	input  wire logic        i_mclk,
	input  wire logic        i_rstn,
	// ahb-lite slave
	input  wire logic        i_hsel,
	input  wire logic [7:0]  i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic             o_hreadyout,
	output logic             o_hresp,
	output logic [31:0]      o_hrdata,
	// asynchronous pins and comparators
	input  wire logic        i_en_pulled_low,
	input  wire logic        i_vin_uvlo,
	input  wire logic        i_overcurrent,
	input  wire logic        i_over_temp,
	input  wire logic        i_fb_below_92,
	input  wire logic        i_fb_below_94,
	input  wire logic        i_fb_above_104,
	input  wire logic        i_fb_above_106,
	input  wire logic        i_dropout,
	input  wire logic        i_gate_cap_undervoltage,
	input  wire logic        i_comp_below_start,
	input  wire logic        i_soft_start_done,
	input  wire logic        i_freq_set_sync_pin,
	input  wire logic        i_addr_strap_bit0,
	input  wire logic        i_addr_strap_bit1,
	// power stage and pins
	output logic             o_cycle_start,
	output logic             o_high_side_allow,
	output logic             o_low_side_allow,
	output logic             o_switch_node_pull_low,
	output logic             o_soft_start_run,
	output logic             o_output_ok_flag_o,
	output logic             o_output_ok_flag_oe_n,
	output logic             o_ext_sync_mode,
	output logic [1:0]       o_serial_addr
);

	////////////////////////////////////////////////////////////////
	// synchronised inputs
	localparam int NS = 15;
	logic [NS-1:0] pins_s;
	logic          en_s, uvlo_s, oc_s, ot_s, lt92_s, lt94_s, gt104_s, gt106_s;
	logic          drop_s, gcuv_s, comp_s, ssd_s, clk_s, a0_s, a1_s;

	bhs_sync2 #(
		.W (NS)
	) u_sync (
		.i_mclk  (i_mclk),
		.i_rstn  (i_rstn),
		.i_async ({i_en_pulled_low, i_vin_uvlo, i_overcurrent, i_over_temp,
		           i_fb_below_92, i_fb_below_94, i_fb_above_104, i_fb_above_106,
		           i_dropout, i_gate_cap_undervoltage, i_comp_below_start,
		           i_soft_start_done, i_freq_set_sync_pin,
		           i_addr_strap_bit0, i_addr_strap_bit1}),
		.o_sync  (pins_s)
	);

	assign {en_s, uvlo_s, oc_s, ot_s, lt92_s, lt94_s, gt104_s, gt106_s,
	        drop_s, gcuv_s, comp_s, ssd_s, clk_s, a0_s, a1_s} = pins_s;

	////////////////////////////////////////////////////////////////
	// bus registers
	logic [1:0]  ctrl_reg, ctrl_next;
	logic [15:0] div_reg, div_next;
	logic        wr_pend_reg, wr_pend_next;
	logic [7:0]  wr_addr_reg, wr_addr_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [31:0] status;
	logic        ap_take;

	// a write lands in its data phase; read data are fetched at the
	// address phase so they stand in the data phase with no wait state
	assign ap_take = i_hsel & i_htrans[1] & i_hready;

	always_comb
	begin
		ctrl_next    = ctrl_reg;
		div_next     = div_reg;
		wr_pend_next = ap_take & i_hwrite;
		wr_addr_next = ap_take ? i_haddr : wr_addr_reg;
		rdata_next   = rdata_reg;
		if (wr_pend_reg)
		begin
			if (wr_addr_reg == bhs_pkg::ADDR_CTRL)
				ctrl_next = i_hwdata[1:0];
			if (wr_addr_reg == bhs_pkg::ADDR_OSC_DIV)
				div_next = i_hwdata[15:0];
		end
		if (ap_take && !i_hwrite)
		begin
			unique case (i_haddr)
				bhs_pkg::ADDR_CTRL:    rdata_next = {30'h0000_0000, ctrl_reg};
				bhs_pkg::ADDR_OSC_DIV: rdata_next = {16'h0000, div_reg};
				bhs_pkg::ADDR_STATUS:  rdata_next = status;
				default:               rdata_next = 32'h0000_0000;
			endcase
		end
		if (!i_rstn)
		begin
			ctrl_next    = bhs_pkg::CTRL_RST;
			div_next     = bhs_pkg::OSC_DIV_RST;
			wr_pend_next = 1'b0;
			wr_addr_next = 8'h00;
			rdata_next   = 32'h0000_0000;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		ctrl_reg    <= ctrl_next;
		div_reg     <= div_next;
		wr_pend_reg <= wr_pend_next;
		wr_addr_reg <= wr_addr_next;
		rdata_reg   <= rdata_next;
	end

	assign o_hreadyout = 1'b1;    // never stalls
	assign o_hresp     = 1'b0;    // always okay, unmapped reads zero
	assign o_hrdata    = rdata_reg;

	////////////////////////////////////////////////////////////////
	// switching-cycle tick: external falling edge or internal divider
	logic                    clk_d_reg, clk_d_next;
	logic                    ext_reg, ext_next;
	logic [bhs_pkg::LOSS_W-1:0] loss_reg, loss_next;
	logic [15:0]             osc_reg, osc_next;
	logic                    fall, tick;

	assign fall = clk_d_reg & ~clk_s;
	// a lost external clock drops back to the internal oscillator
	assign tick = (ext_reg & ~ctrl_reg[bhs_pkg::CTRL_FORCE_INT]) ? fall
	            : (osc_reg == div_reg - 16'h0001);

	always_comb
	begin
		clk_d_next = clk_s;
		osc_next   = (osc_reg >= div_reg - 16'h0001) ? 16'h0000 : osc_reg + 16'h0001;
		ext_next   = ext_reg;
		loss_next  = loss_reg;
		if (fall)
		begin
			ext_next  = 1'b1;
			loss_next = '0;
		end
		else if (loss_reg == bhs_pkg::LOSS_W'(bhs_pkg::EXT_LOSS_CYC))
			ext_next = 1'b0;
		else
			loss_next = loss_reg + bhs_pkg::LOSS_W'(1);
		if (!i_rstn)
		begin
			clk_d_next = 1'b0;
			osc_next   = 16'h0000;
			ext_next   = 1'b0;
			loss_next  = '0;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		clk_d_reg <= clk_d_next;
		osc_reg   <= osc_next;
		ext_reg   <= ext_next;
		loss_reg  <= loss_next;
	end

	////////////////////////////////////////////////////////////////
	// address straps, caught once the synchroniser has settled
	logic [1:0] strap_cnt_reg, strap_cnt_next;
	logic [1:0] addr_reg, addr_next;

	always_comb
	begin
		strap_cnt_next = strap_cnt_reg;
		addr_next      = addr_reg;
		// counter parks one past the capture point, so the straps are read once
		if (strap_cnt_reg != 2'(bhs_pkg::STRAP_SETTLE + 1))
			strap_cnt_next = strap_cnt_reg + 2'h1;
		if (strap_cnt_reg == 2'(bhs_pkg::STRAP_SETTLE))
			addr_next = {a1_s, a0_s};    // pull-up makes a float read one
		if (!i_rstn)
		begin
			strap_cnt_next = 2'h0;
			addr_next      = 2'h0;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		strap_cnt_reg <= strap_cnt_next;
		addr_reg      <= addr_next;
	end

	////////////////////////////////////////////////////////////////
	// sequencer: soft start, run, overcurrent and thermal hiccup
	bhs_pkg::bhs_state_type        state_reg, state_next;
	logic [bhs_pkg::TMR_W-1:0]     tmr_reg, tmr_next;
	logic [bhs_pkg::OCC_W-1:0]     occ_reg, occ_next;
	logic                          ocs_reg, ocs_next;
	logic                          ovp_reg, ovp_next;
	logic                          seq_rst, oc_hit, active;

	// undriven enable floats high by the pull-up, so only a pull low stops;
	// held off until the synchroniser has flushed, else a pulled-low enable
	// reads as enabled for two cycles after reset and slips a start through
	assign seq_rst = ~i_rstn | en_s | uvlo_s
	               | (strap_cnt_reg < 2'(bhs_pkg::STRAP_SETTLE))
	               | ctrl_reg[bhs_pkg::CTRL_SW_OFF_BIT];
	assign oc_hit  = ocs_reg | oc_s;
	assign active  = (state_reg == bhs_pkg::ST_SOFT) | (state_reg == bhs_pkg::ST_RUN);

	always_comb
	begin
		state_next = state_reg;
		tmr_next   = tmr_reg;
		occ_next   = occ_reg;
		ocs_next   = tick ? 1'b0 : oc_hit;    // overload seen in this cycle
		// set wins over clear while the comparator still reads high
		ovp_next   = gt106_s | (ovp_reg & gt104_s);
		unique case (state_reg)
			bhs_pkg::ST_OFF:
				state_next = bhs_pkg::ST_SOFT;
			bhs_pkg::ST_SOFT, bhs_pkg::ST_RUN:
			begin
				if (state_reg == bhs_pkg::ST_SOFT && ssd_s)
					state_next = bhs_pkg::ST_RUN;
				if (ot_s)
					state_next = bhs_pkg::ST_OT_WAIT;
				else if (tick && !oc_hit)
					occ_next = '0;
				else if (tick && occ_reg == bhs_pkg::OCC_W'(OC_PERSIST_CYC))
				begin
					state_next = bhs_pkg::ST_OC_HIC;
					tmr_next   = '0;
					occ_next   = '0;
				end
				else if (tick)
					occ_next = occ_reg + bhs_pkg::OCC_W'(1);
			end
			bhs_pkg::ST_OC_HIC:
			begin
				if (ot_s)
					state_next = bhs_pkg::ST_OT_WAIT;
				else if (tick && tmr_reg == bhs_pkg::TMR_W'(OC_HICCUP_CYC - 1))
					state_next = bhs_pkg::ST_SOFT;
				else if (tick)
					tmr_next = tmr_reg + bhs_pkg::TMR_W'(1);
			end
			bhs_pkg::ST_OT_WAIT:
			begin
				tmr_next = '0;
				if (!ot_s)
					state_next = bhs_pkg::ST_OT_HIC;
			end
			bhs_pkg::ST_OT_HIC:
			begin
				if (ot_s)
					state_next = bhs_pkg::ST_OT_WAIT;
				else if (tick && tmr_reg == bhs_pkg::TMR_W'(OT_HICCUP_CYC - 1))
					state_next = bhs_pkg::ST_SOFT;
				else if (tick)
					tmr_next = tmr_reg + bhs_pkg::TMR_W'(1);
			end
			default:
				state_next = bhs_pkg::ST_OFF;
		endcase
		if (seq_rst)
		begin
			state_next = bhs_pkg::ST_OFF;
			tmr_next   = '0;
			occ_next   = '0;
			ocs_next   = 1'b0;
			ovp_next   = 1'b0;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		state_reg <= state_next;
		tmr_reg   <= tmr_next;
		occ_reg   <= occ_next;
		ocs_reg   <= ocs_next;
		ovp_reg   <= ovp_next;
	end

	////////////////////////////////////////////////////////////////
	// power-good window and registered drive outputs
	logic pg_win_reg, pg_win_next;
	logic pg_reg, pg_next;
	logic cyc_reg, cyc_next, hs_reg, hs_next, ls_reg, ls_next;
	logic pl_reg, pl_next, ss_reg, ss_next;
	logic pulse_ok;

	// pulses are suppressed while compensation sits below its threshold
	assign pulse_ok = active & ~comp_s;

	always_comb
	begin
		pg_win_next = pg_win_reg;
		if (lt92_s | gt106_s)
			pg_win_next = 1'b0;
		else if (!lt94_s && !gt104_s)
			pg_win_next = 1'b1;
		// soft start counts as not good even if the window is met
		pg_next  = pg_win_reg & (state_reg == bhs_pkg::ST_RUN) & ~ot_s
		         & ~drop_s & ~ovp_reg & ~seq_rst;
		cyc_next = tick & pulse_ok;
		// full duty is legal; only a low bootstrap, overvoltage or low compensation breaks it
		hs_next  = pulse_ok & ~ovp_reg & ~gcuv_s;
		ls_next  = active;
		pl_next  = active & gcuv_s;
		ss_next  = active;    // low discharges the ramp for a fresh start
		if (!i_rstn)
		begin
			pg_win_next = 1'b0;
			pg_next     = 1'b0;
			cyc_next    = 1'b0;
			hs_next     = 1'b0;
			ls_next     = 1'b0;
			pl_next     = 1'b0;
			ss_next     = 1'b0;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		pg_win_reg <= pg_win_next;
		pg_reg     <= pg_next;
		cyc_reg    <= cyc_next;
		hs_reg     <= hs_next;
		ls_reg     <= ls_next;
		pl_reg     <= pl_next;
		ss_reg     <= ss_next;
	end

	assign o_cycle_start          = cyc_reg;
	assign o_high_side_allow      = hs_reg;
	assign o_low_side_allow       = ls_reg;
	assign o_switch_node_pull_low = pl_reg;
	assign o_soft_start_run       = ss_reg;
	assign o_output_ok_flag_o     = 1'b0;      // open drain only pulls low
	assign o_output_ok_flag_oe_n  = pg_reg;    // released when good
	assign o_ext_sync_mode        = ext_reg;
	assign o_serial_addr          = addr_reg;

	// status word for software
	always_comb
	begin
		status = 32'h0000_0000;
		status[bhs_pkg::STAT_STATE_LSB +: 3] = state_reg;
		status[bhs_pkg::STAT_EXT_BIT]        = ext_reg;
		status[bhs_pkg::STAT_PG_BIT]         = pg_reg;
		status[bhs_pkg::STAT_OVP_BIT]        = ovp_reg;
		status[bhs_pkg::STAT_OT_BIT]         = ot_s;
		status[bhs_pkg::STAT_ADDR_LSB +: 2]  = addr_reg;
	end

endmodule : bhs_sequencer

// [tb/bhs_properties.sv]
/*
 checker: protection, flag and strap relations at the sequencer ports.
 assumes 2-flop input sync and registered outputs, about 4 edges pin to pin.
*/
`timescale 1ns/1ps

module bhs_properties (
	input wire logic       i_mclk,
	input wire logic       i_rstn,
	input wire logic       i_en_pulled_low,
	input wire logic       i_vin_uvlo,
	input wire logic       i_over_temp,
	input wire logic       i_fb_below_92,
	input wire logic       i_fb_above_106,
	input wire logic       i_dropout,
	input wire logic       i_gate_cap_undervoltage,
	input wire logic       i_comp_below_start,
	input wire logic       o_cycle_start,
	input wire logic       o_high_side_allow,
	input wire logic       o_low_side_allow,
	input wire logic       o_switch_node_pull_low,
	input wire logic       o_soft_start_run,
	input wire logic       o_output_ok_flag_oe_n,
	input wire logic [1:0] o_serial_addr
);
	default clocking dc @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);

	logic [2:0] rel_reg;
	logic [2:0] rel_next;

	////////////////////////////////////////////////////////////////
	// edges since reset release, saturating; straps are long captured at the top
	always_comb
	begin
		rel_next = (rel_reg == 3'h7) ? rel_reg : rel_reg + 3'h1;
		if (!i_rstn)
			rel_next = 3'h0;
	end

	always_ff @(posedge i_mclk)
		rel_reg <= rel_next;

	// six cycles covers sync, state and output registers with one spare
	chk_hot_stops: assert property (
		i_over_temp [*6] |-> !o_high_side_allow && !o_low_side_allow)
		else $error("switching while hot");
	chk_off_resets: assert property (
		(i_en_pulled_low || i_vin_uvlo) [*6] |->
		!o_low_side_allow && !o_soft_start_run && !o_output_ok_flag_oe_n)
		else $error("running while disabled");
	chk_flag_faults: assert property (
		(i_fb_below_92 || i_fb_above_106 || i_dropout) [*6] |-> !o_output_ok_flag_oe_n)
		else $error("flag released in fault");
	chk_flag_soft: assert property (
		$rose(o_soft_start_run) |-> !o_output_ok_flag_oe_n)
		else $error("flag released at soft start");
	chk_ovp_block: assert property (
		i_fb_above_106 [*6] |-> !o_high_side_allow)
		else $error("high side on in overvoltage");
	chk_boot_refresh: assert property (
		i_gate_cap_undervoltage [*6] ##0 o_low_side_allow |-> o_switch_node_pull_low)
		else $error("no bootstrap refresh");
	chk_comp_quiet: assert property (
		i_comp_below_start [*6] |-> !o_cycle_start)
		else $error("pulse with low compensation");
	chk_strap_hold: assert property (
		rel_reg == 3'h7 |-> $stable(o_serial_addr))
		else $error("address changed after capture");

	cover property ($rose(o_output_ok_flag_oe_n));
	cover property ($fell(o_high_side_allow) && o_low_side_allow);
	cover property ($rose(o_switch_node_pull_low));
endmodule : bhs_properties

// [tb/bhs_analog_model.sv]
/*
 analog side: feedback comparators, soft-start capacitor and strap pins.
 assumes feedback given in percent of reference, straps as float flags.
*/
`timescale 1ns/1ps

module bhs_analog_model #(
	parameter int SS_CYC = 20
) (
	input  wire logic       i_mclk,
	input  wire logic [7:0] i_fb_pct,
	input  wire logic       i_soft_start_run,
	input  wire logic [1:0] i_strap_float,
	output logic      [3:0] o_fb_cmp,
	output logic            o_soft_start_done,
	output logic      [1:0] o_strap
);
	int ss_cnt = 0;

	////////////////////////////////////////////////////////////////
	// comparators {below 92, below 94, above 104, above 106}
	assign o_fb_cmp = {i_fb_pct < 8'h5c, i_fb_pct < 8'h5e, i_fb_pct > 8'h68, i_fb_pct > 8'h6a};
	// pull-up makes a floating strap read high, a grounded one low
	assign o_strap = i_strap_float;

	// ramp restarts from zero whenever the capacitor is discharged
	always @(posedge i_mclk)
		ss_cnt <= !i_soft_start_run ? 0 : (ss_cnt < SS_CYC ? ss_cnt + 1 : ss_cnt);

	assign o_soft_start_done = (ss_cnt == SS_CYC);
endmodule : bhs_analog_model

// [tb/bhs_sequencer_tb_top.sv]
/*
 bench for the sequencer: registers, start, hiccups, flag window, sync clock.
 assumes the analog model answers comparators and soft-start completion.
*/
`timescale 1ns/1ps

module bhs_sequencer_tb_top;
	localparam int DIV = 4; // shortened switching period in mclk cycles
	localparam int OCH = 8;
	localparam int OTH = 8;
	logic        mclk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hrdyo, hresp;
	logic [7:0]  haddr = 8'h00, fb = 8'h64;
	logic [1:0]  htrans = 2'h0, saddr, strap, sfl = 2'h1;
	logic [31:0] hwdata = 32'h0000_0000, hrdata, rd;
	logic        en_low = 1'b1, uvlo = 1'b0, oc = 1'b0, hot = 1'b0, drop = 1'b0;
	logic        guv = 1'b0, cbs = 1'b0, sync_pin = 1'b1, ext_on = 1'b0, ss_done;
	logic [3:0]  fbc;
	logic        cst, hsa, lsa, pull, ssr, flag_oe_n, ext_md, flag_o;
	logic [7:0]  fbt [8] = '{8'h5d, 8'h5b, 8'h5d, 8'h5f, 8'h69, 8'h6b, 8'h69, 8'h64};
	logic [7:0]  pgt = 8'h99;
	logic [7:0]  hst = 8'h9f;
	int          fail_count = 0, n_compared = 0, cyc = 0, n, t0;

	bhs_sequencer #(.OC_PERSIST_CYC(4), .OC_HICCUP_CYC(OCH), .OT_HICCUP_CYC(OTH)) dut (
		.i_mclk(mclk), .i_rstn(rstn), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdyo),
		.o_hreadyout(hrdyo), .o_hresp(hresp), .o_hrdata(hrdata), .i_en_pulled_low(en_low),
		.i_vin_uvlo(uvlo), .i_overcurrent(oc), .i_over_temp(hot), .i_fb_below_92(fbc[3]),
		.i_fb_below_94(fbc[2]), .i_fb_above_104(fbc[1]), .i_fb_above_106(fbc[0]),
		.i_dropout(drop), .i_gate_cap_undervoltage(guv), .i_comp_below_start(cbs),
		.i_soft_start_done(ss_done), .i_freq_set_sync_pin(sync_pin),
		.i_addr_strap_bit0(strap[0]), .i_addr_strap_bit1(strap[1]), .o_cycle_start(cst),
		.o_high_side_allow(hsa), .o_low_side_allow(lsa), .o_switch_node_pull_low(pull),
		.o_soft_start_run(ssr), .o_output_ok_flag_o(flag_o), .o_output_ok_flag_oe_n(flag_oe_n),
		.o_ext_sync_mode(ext_md), .o_serial_addr(saddr));

	bhs_analog_model u_model (.i_mclk(mclk), .i_fb_pct(fb), .i_soft_start_run(ssr),
		.i_strap_float(sfl), .o_fb_cmp(fbc), .o_soft_start_done(ss_done), .o_strap(strap));

	////////////////////////////////////////////////////////////////
	// clock, hang limit, external sync clock of 12 mclk period
	always #4 mclk = ~mclk;

	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (ext_on && cyc % 6 == 0)
			sync_pin <= ~sync_pin;
		if (cyc == 10000)
		begin
			fail_count++;
			summarize();
		end
	end

	// comparisons: exact value, and a count within bounds
	task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", w, e, g);
		end
	endtask : chk

	task automatic rng(input string w, input int lo, input int hi, input int g);
		n_compared++;
		if (g < lo || g > hi)
		begin
			fail_count++;
			$display("BAD %s expected %0d..%0d seen %0d", w, lo, hi, g);
		end
	endtask : rng

	// single ahb-lite transfer; hready is the slave's own hreadyout
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge mclk); while (hrdyo !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hrdyo !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk($sformatf("reg %h", a), e, rd & m);
		chk("hresp", 32'h0000_0000, hresp);
	endtask : rdc

	// bounded wait for a level; a miss leaves c at the limit
	task automatic wt(ref logic s, input logic v, input int lim, output int c);
		c = 0;
		while (s !== v && c < lim)
		begin
			@(posedge mclk);
			c++;
		end
	endtask : wt

	task automatic pulses(input int len, output int c);
		c = 0;
		repeat (len)
		begin
			@(posedge mclk);
			c += int'(cst === 1'b1);
		end
	endtask : pulses

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	////////////////////////////////////////////////////////////////
	// main sequence; each step from start to sync leaves the converter running for the next
	initial
	begin
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		repeat (6) @(posedge mclk);
		rdc(8'h04, 32'hffff_ffff, 32'h0000_00fa);
		rdc(8'h08, 32'h0000_0187, 32'h0000_0080);
		chk("serial_addr", 2'h1, saddr);
		bus(1'b1, 8'h0c, 32'hffff_ffff);
		rdc(8'h0c, 32'hffff_ffff, 32'h0000_0000);
		bus(1'b1, 8'h04, DIV);
		rdc(8'h04, 32'hffff_ffff, DIV);
		$display("test registers done");
		en_low <= 1'b0;
		wt(lsa, 1'b1, 12, n);
		rng("start_delay", 1, 8, n);
		chk("flag_in_soft", 1'b0, flag_oe_n);
		wt(flag_oe_n, 1'b1, 100, n);
		rdc(8'h08, 32'h0000_0017, 32'h0000_0013);
		$display("test start done");
		repeat (2)
		begin
			oc <= 1'b1;
			repeat (3 * DIV) @(posedge mclk);
			oc <= 1'b0;
			repeat (3 * DIV) @(posedge mclk);
		end
		chk("broken_overload", 1'b1, hsa);
		oc <= 1'b1;
		wt(hsa, 1'b0, 60, n);
		t0 = cyc;
		oc <= 1'b0;
		rng("overload_trip", 4 * DIV, 6 * DIV + 6, n);
		rdc(8'h08, 32'h0000_0007, 32'h0000_0002);
		chk("overload_low_side", 1'b0, lsa);
		wt(lsa, 1'b1, 300, n);
		rng("overload_hiccup", OCH * DIV - DIV, OCH * DIV + DIV + 8, cyc - t0);
		wt(flag_oe_n, 1'b1, 100, n);
		$display("test overload done");
		hot <= 1'b1;
		wt(hsa, 1'b0, 10, n);
		rng("hot_stop", 1, 6, n);
		repeat (100) @(posedge mclk);
		rdc(8'h08, 32'h0000_0007, 32'h0000_0006);
		chk("thermal_ramp_off", 1'b0, ssr);
		hot <= 1'b0;
		t0 = cyc;
		wt(lsa, 1'b1, 300, n);
		rng("thermal_hiccup", OTH * DIV - DIV, OTH * DIV + DIV + 8, cyc - t0);
		rdc(8'h08, 32'h0000_0007, 32'h0000_0001);
		wt(flag_oe_n, 1'b1, 100, n);
		$display("test thermal done");
		foreach (fbt[i])
		begin
			fb <= fbt[i];
			repeat (8) @(posedge mclk);
			chk("flag_window", pgt[i], flag_oe_n);
			chk("overvoltage_block", hst[i], hsa);
		end
		drop <= 1'b1;
		repeat (8) @(posedge mclk);
		chk("flag_dropout", 1'b0, flag_oe_n);
		chk("flag_drive", 1'b0, flag_o);
		drop <= 1'b0;
		guv <= 1'b1;
		repeat (8) @(posedge mclk);
		chk("refresh_on", 1'b1, pull);
		guv <= 1'b0;
		repeat (8) @(posedge mclk);
		chk("refresh_off", 1'b0, pull);
		cbs <= 1'b1;
		repeat (6) @(posedge mclk);
		pulses(40, n);
		rng("pulses_blocked", 0, 0, n);
		cbs <= 1'b0;
		repeat (6) @(posedge mclk);
		pulses(40, n);
		rng("pulses_internal", 9, 11, n);
		$display("test window done");
		ext_on <= 1'b1;
		repeat (60) @(posedge mclk);
		chk("ext_mode", 1'b1, ext_md);
		pulses(120, n);
		rng("pulses_external", 9, 11, n);
		bus(1'b1, 8'h00, 32'h0000_0002);
		rdc(8'h00, 32'hffff_ffff, 32'h0000_0002);
		pulses(40, n);
		rng("pulses_forced", 9, 11, n);
		bus(1'b1, 8'h00, 32'h0000_0000);
		ext_on <= 1'b0;
		repeat (1300) @(posedge mclk);
		chk("ext_lost", 1'b0, ext_md);
		$display("test sync done");
		oc <= 1'b1;
		wt(hsa, 1'b0, 60, n);
		oc <= 1'b0;
		uvlo <= 1'b1;
		repeat (8) @(posedge mclk);
		rdc(8'h08, 32'h0000_0007, 32'h0000_0000);
		uvlo <= 1'b0;
		wt(lsa, 1'b1, 12, n);
		rng("restart_after_uvlo", 1, 8, n);
		bus(1'b1, 8'h00, 32'h0000_0001);
		repeat (8) @(posedge mclk);
		chk("sw_off_low_side", 1'b0, lsa);
		bus(1'b1, 8'h00, 32'h0000_0000);
		en_low <= 1'b1;
		repeat (8) @(posedge mclk);
		chk("disabled_low_side", 1'b0, lsa);
		chk("disabled_flag", 1'b0, flag_oe_n);
		$display("test shutdown done");
		sfl <= 2'h2;
		rstn <= 1'b0;
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		repeat (4)
		begin
			@(posedge mclk);
			chk("quiet_after_reset", 1'b0, lsa);
		end
		repeat (2) @(posedge mclk);
		chk("strap_after_reset", 2'h2, saddr);
		sfl <= 2'h1;
		repeat (6) @(posedge mclk);
		chk("strap_held", 2'h2, saddr);
		$display("test strap done");
		summarize();
	end
endmodule : bhs_sequencer_tb_top

bind bhs_sequencer bhs_properties u_props (.i_mclk(i_mclk), .i_rstn(i_rstn),
	.i_en_pulled_low(i_en_pulled_low), .i_vin_uvlo(i_vin_uvlo), .i_over_temp(i_over_temp),
	.i_fb_below_92(i_fb_below_92), .i_fb_above_106(i_fb_above_106), .i_dropout(i_dropout),
	.i_gate_cap_undervoltage(i_gate_cap_undervoltage), .i_comp_below_start(i_comp_below_start),
	.o_cycle_start(o_cycle_start), .o_high_side_allow(o_high_side_allow),
	.o_low_side_allow(o_low_side_allow), .o_switch_node_pull_low(o_switch_node_pull_low),
	.o_soft_start_run(o_soft_start_run), .o_output_ok_flag_oe_n(o_output_ok_flag_oe_n),
	.o_serial_addr(o_serial_addr));
